// ### hw/nfs_host.sv
// host controller issuing set-features and get-features to an asynchronous flash target
//
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
`include "nfs_map.svh"

//Behaviour
//- Set and get features only while every die on the target is idle.
//- Host sends one feature address cycle, waits address-to-data delay, then parameters.
//- After polling with read-status, host issues read-mode before reading parameters.
//- After busy ends, host enables output and target returns bytes in order.
module nfs_host (
    input  wire logic        sys_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [4:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [4:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    output logic             nand_ce_n_o,
    output logic             nand_cle_o,
    output logic             nand_ale_o,
    output logic             nand_we_n_o,
    output logic             nand_re_n_o,
    output logic [7:0]       nand_io_o,
    output logic             nand_io_oe_o,
    input  wire logic [7:0]  nand_io_i,
    input  wire logic        nand_rb_n_i
);
    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] param_mask(input logic [7:0] fa);
        case (fa)
            `NFS_FA_TIMING:               param_mask = `NFS_MASK_TIMING;
            `NFS_FA_DRIVE, `NFS_FA_RBPULL: param_mask = `NFS_MASK_2BIT;
            `NFS_FA_ARRAY:                param_mask = `NFS_MASK_ARRAY;
            default:                      param_mask = 32'hffff_ffff;
        endcase
    endfunction : param_mask

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [2:0] rb_sync;
    logic       rb_ready;
    logic [7:0] io_s1, io_s2, io_s3, io_q;
    always_ff @(posedge sys_clk_i) begin
        rb_sync <= {rb_sync[1:0], nand_rb_n_i};
        io_s1   <= nand_io_i;
        io_s2   <= io_s1;
        io_s3   <= io_s2;
        if (sys_rst_i) begin
            rb_ready <= 1'b0;
            io_q     <= 8'h00;
        end else begin
            if (rb_sync[1] == rb_sync[2])
                rb_ready <= rb_sync[2];
            if (io_s2 == io_s3)
                io_q <= io_s3;
        end
    end

    // ****************************************************************
    // register file and AXI4-Lite slave
    // ****************************************************************
    nfs_pkg::nfs_state_t state, next_state;
    logic [7:0]  feat_addr;
    logic [31:0] wparams, rparams;
    logic [7:0]  last_status;
    logic        done, refused, use_poll, is_get;
    logic [4:0]  aw_q;
    logic [31:0] w_q;
    logic        aw_held, w_held, ws_q;
    logic [31:0] rd_mux;

    wire        aw_take  = s_axi_awvalid_i & s_axi_awready_o;
    wire        w_take   = s_axi_wvalid_i & s_axi_wready_o;
    wire        wr_fire  = aw_held & w_held & ~s_axi_bvalid_o;
    wire [3:0]  wr_idx   = {1'b0, aw_q[4:2]};
    wire        wr_map   = wr_idx <= `NFS_REG_WDATA;
    wire        ctrl_wr  = wr_fire & (wr_idx == `NFS_REG_CTRL);
    wire        set_req  = ctrl_wr & w_q[`NFS_CTRL_SET_BIT];
    wire        get_req  = ctrl_wr & w_q[`NFS_CTRL_GET_BIT];
    wire        clr_req  = ctrl_wr & w_q[`NFS_CTRL_CLR_BIT];
    wire        can_go   = (state == nfs_pkg::NFS_IDLE) & rb_ready;
    wire        start    = (set_req | get_req) & can_go;
    wire [3:0]  rd_idx   = {1'b0, s_axi_araddr_i[4:2]};
    wire        rd_map   = rd_idx <= `NFS_REG_STATUS;
    wire [31:0] status_w = {16'h0000, last_status, 4'h0, refused,
                            rb_ready, done, state != nfs_pkg::NFS_IDLE};

    assign s_axi_awready_o = ~aw_held;
    assign s_axi_wready_o  = ~w_held;
    assign s_axi_arready_o = ~s_axi_rvalid_o;
    assign rd_mux = (rd_idx == `NFS_REG_CTRL)  ? {31'h0, use_poll} :
                    (rd_idx == `NFS_REG_ADDR)  ? {24'h0, feat_addr} :
                    (rd_idx == `NFS_REG_WDATA) ? wparams :
                    (rd_idx == `NFS_REG_RDATA) ? rparams :
                    (rd_idx == `NFS_REG_STATUS) ? status_w : 32'h0000_0000;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            aw_held        <= 1'b0;
            w_held         <= 1'b0;
            aw_q           <= 5'h00;
            w_q            <= 32'h0000_0000;
            ws_q           <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= `NFS_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_q    <= s_axi_awaddr_i;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_q    <= s_axi_wdata_i;
                ws_q   <= s_axi_wstrb_i[0];
            end
            if (wr_fire) begin
                aw_held        <= 1'b0;
                w_held         <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o  <= wr_map ? `NFS_RESP_OKAY : `NFS_RESP_SLVERR;
            end else if (s_axi_bready_i)
                s_axi_bvalid_o <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= 32'h0000_0000;
            s_axi_rresp_o  <= `NFS_RESP_OKAY;
        end else if (s_axi_arvalid_i & s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= rd_mux;
            s_axi_rresp_o  <= rd_map ? `NFS_RESP_OKAY : `NFS_RESP_SLVERR;
        end else if (s_axi_rready_i)
            s_axi_rvalid_o <= 1'b0;
    end

    // ****************************************************************
    // command sequencer
    // ****************************************************************
    logic [7:0] cnt;
    logic [1:0] bidx;
    wire        wr_state = (state == nfs_pkg::NFS_CMD) | (state == nfs_pkg::NFS_ADDR) |
                           (state == nfs_pkg::NFS_DATA_W) | (state == nfs_pkg::NFS_POLL_CMD) |
                           (state == nfs_pkg::NFS_MODE_CMD);
    wire        rd_state = (state == nfs_pkg::NFS_POLL_RD) | (state == nfs_pkg::NFS_DATA_R);
    wire        wr_end   = wr_state & (cnt == 8'(`NFS_WR_TOT - 1));
    wire        rd_end   = rd_state & (cnt == 8'(`NFS_RD_TOT - 1));
    wire        rd_smp   = rd_state & (cnt == 8'(`NFS_RD_SMP));
    wire        adl_end  = cnt == 8'(`NFS_ADL_CYC - 1);
    wire        wb_end   = cnt == 8'(`NFS_WB_CYC - 1);
    wire [7:0]  wbyte    = wparams[8*bidx +: 8];
    wire [7:0]  cmd_byte = (state == nfs_pkg::NFS_POLL_CMD) ? `NFS_CMD_STATUS :
                           (state == nfs_pkg::NFS_MODE_CMD) ? `NFS_CMD_READMODE :
                           is_get ? `NFS_CMD_GET : `NFS_CMD_SET;
    wire [7:0]  next_io  = (state == nfs_pkg::NFS_ADDR)   ? feat_addr :
                           (state == nfs_pkg::NFS_DATA_W) ? wbyte : cmd_byte;
    wire        stat_rdy = io_q[`NFS_SR_RDY_BIT];

    always_comb begin
        next_state = state;
        case (state)
            nfs_pkg::NFS_IDLE:     if (start) next_state = nfs_pkg::NFS_CMD;
            nfs_pkg::NFS_CMD:      if (wr_end) next_state = nfs_pkg::NFS_ADDR;
            nfs_pkg::NFS_ADDR:     if (wr_end) next_state = is_get ? nfs_pkg::NFS_WAIT_WB
                                                                   : nfs_pkg::NFS_ADL;
            nfs_pkg::NFS_ADL:      if (adl_end) next_state = nfs_pkg::NFS_DATA_W;
            nfs_pkg::NFS_DATA_W:   if (wr_end && bidx == 2'd3) next_state = nfs_pkg::NFS_WAIT_WB;
            nfs_pkg::NFS_WAIT_WB:  if (wb_end) next_state = use_poll ? nfs_pkg::NFS_POLL_CMD
                                                                     : nfs_pkg::NFS_WAIT_RB;
            nfs_pkg::NFS_WAIT_RB:  if (rb_ready) next_state = is_get ? nfs_pkg::NFS_DATA_R
                                                                     : nfs_pkg::NFS_DONE;
            nfs_pkg::NFS_POLL_CMD: if (wr_end) next_state = nfs_pkg::NFS_POLL_RD;
            nfs_pkg::NFS_POLL_RD:  if (rd_end && stat_rdy)
                                       next_state = is_get ? nfs_pkg::NFS_MODE_CMD
                                                           : nfs_pkg::NFS_DONE;
            nfs_pkg::NFS_MODE_CMD: if (wr_end) next_state = nfs_pkg::NFS_DATA_R;
            nfs_pkg::NFS_DATA_R:   if (rd_end && bidx == 2'd3) next_state = nfs_pkg::NFS_DONE;
            nfs_pkg::NFS_DONE:     next_state = nfs_pkg::NFS_IDLE;
            default:               next_state = nfs_pkg::NFS_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state <= nfs_pkg::NFS_IDLE;
            cnt   <= 8'h00;
            bidx  <= 2'd0;
        end else begin
            state <= next_state;
            cnt   <= (next_state != state || rd_end || wr_end) ? 8'h00 : cnt + 8'h01;
            if (state == nfs_pkg::NFS_IDLE)
                bidx <= 2'd0;
            else if ((state == nfs_pkg::NFS_DATA_W && wr_end) ||
                     (state == nfs_pkg::NFS_DATA_R && rd_end))
                bidx <= bidx + 2'd1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            feat_addr   <= 8'h00;
            wparams     <= 32'h0000_0000;
            rparams     <= 32'h0000_0000;
            last_status <= 8'h00;
            use_poll    <= 1'b0;
            is_get      <= 1'b0;
            done        <= 1'b0;
            refused     <= 1'b0;
        end else begin
            if (wr_fire && wr_idx == `NFS_REG_ADDR && ws_q)
                feat_addr <= w_q[7:0];
            if (wr_fire && wr_idx == `NFS_REG_WDATA && state == nfs_pkg::NFS_IDLE)
                wparams <= w_q;
            if (ctrl_wr && state == nfs_pkg::NFS_IDLE)
                use_poll <= w_q[`NFS_CTRL_POLL_BIT];
            if (start) begin
                is_get  <= get_req;
                wparams <= wparams & param_mask(feat_addr);
            end
            if (rd_smp && state == nfs_pkg::NFS_POLL_RD)
                last_status <= io_q;
            if (rd_smp && state == nfs_pkg::NFS_DATA_R)
                rparams[8*bidx +: 8] <= io_q;
            if (state == nfs_pkg::NFS_DONE)
                done <= 1'b1;
            else if (clr_req || start)
                done <= 1'b0;
            if ((set_req | get_req) & ~can_go)
                refused <= 1'b1;
            else if (clr_req)
                refused <= 1'b0;
        end
    end

    // ****************************************************************
    // pin drivers
    // ****************************************************************
    wire next_cle = (state == nfs_pkg::NFS_CMD) | (state == nfs_pkg::NFS_POLL_CMD) |
                    (state == nfs_pkg::NFS_MODE_CMD);
    wire next_we  = wr_state & (cnt < 8'(`NFS_WE_LO));
    wire next_re  = rd_state & (cnt < 8'(`NFS_RE_LO));
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            nand_ce_n_o  <= 1'b1;
            nand_cle_o   <= 1'b0;
            nand_ale_o   <= 1'b0;
            nand_we_n_o  <= 1'b1;
            nand_re_n_o  <= 1'b1;
            nand_io_o    <= 8'h00;
            nand_io_oe_o <= 1'b0;
        end else begin
            nand_ce_n_o  <= state == nfs_pkg::NFS_IDLE;
            nand_cle_o   <= next_cle;
            nand_ale_o   <= state == nfs_pkg::NFS_ADDR;
            nand_we_n_o  <= ~next_we;
            nand_re_n_o  <= ~next_re;
            nand_io_o    <= wr_state ? next_io : 8'h00;
            nand_io_oe_o <= wr_state;
        end
    end
endmodule : nfs_host

// ### include/nfs_map.svh
// register offsets, field positions, command codes and timing counts of the feature host
`ifndef NFS_MAP_SVH
`define NFS_MAP_SVH
// ****************************************************************
// register map
// ****************************************************************
`define NFS_REG_CTRL      4'h0
`define NFS_REG_ADDR      4'h1
`define NFS_REG_WDATA     4'h2
`define NFS_REG_RDATA     4'h3
`define NFS_REG_STATUS    4'h4
`define NFS_CTRL_SET_BIT  0
`define NFS_CTRL_GET_BIT  1
`define NFS_CTRL_POLL_BIT 2
`define NFS_CTRL_CLR_BIT  3
`define NFS_ST_BUSY_BIT   0
`define NFS_ST_DONE_BIT   1
`define NFS_ST_RDY_BIT    2
`define NFS_ST_REF_BIT    3
`define NFS_RESP_OKAY     2'h0
`define NFS_RESP_SLVERR   2'h2
// ****************************************************************
// target commands and feature addresses
// ****************************************************************
`define NFS_CMD_SET       8'hef
`define NFS_CMD_GET       8'hee
`define NFS_CMD_STATUS    8'h70
`define NFS_CMD_READMODE  8'h00
`define NFS_FA_TIMING     8'h01
`define NFS_FA_DRIVE      8'h80
`define NFS_FA_RBPULL     8'h81
`define NFS_FA_ARRAY      8'h90
`define NFS_MASK_TIMING   32'h0000_0007
`define NFS_MASK_2BIT     32'h0000_0003
`define NFS_MASK_ARRAY    32'h0000_0008
`define NFS_SR_RDY_BIT    6
// ****************************************************************
// timing, 40 MHz clock
// ****************************************************************
`define NFS_CLK_NS        25
`define NFS_ADL_NS        70
`define NFS_WB_NS         100
`define NFS_ADL_CYC       ((`NFS_ADL_NS + `NFS_CLK_NS - 1) / `NFS_CLK_NS)
`define NFS_WB_CYC        ((`NFS_WB_NS + `NFS_CLK_NS - 1) / `NFS_CLK_NS)
`define NFS_WE_LO         2
`define NFS_WR_TOT        4
`define NFS_RE_LO         8
`define NFS_RD_SMP        7
`define NFS_RD_TOT        12
`endif

// ### include/nfs_pkg.sv
// types of the feature host
package nfs_pkg;
    typedef enum logic [3:0] {
        NFS_IDLE     = 4'h0,
        NFS_CMD      = 4'h1,
        NFS_ADDR     = 4'h3,
        NFS_ADL      = 4'h2,
        NFS_DATA_W   = 4'h6,
        NFS_WAIT_WB  = 4'h7,
        NFS_WAIT_RB  = 4'h5,
        NFS_POLL_CMD = 4'h4,
        NFS_POLL_RD  = 4'hc,
        NFS_MODE_CMD = 4'hd,
        NFS_DATA_R   = 4'hf,
        NFS_DONE     = 4'he
    } nfs_state_t;
endpackage : nfs_pkg

// ### verif/nfs_host_assertions.sv
// concurrent checks on the flash pins of the feature host
`timescale 1ns/10ps
`include "nfs_map.svh"
module nfs_host_chk (
    input wire logic       sys_clk_i,
    input wire logic       sys_rst_i,
    input wire logic       nand_ce_n_o,
    input wire logic       nand_cle_o,
    input wire logic       nand_ale_o,
    input wire logic       nand_we_n_o,
    input wire logic       nand_re_n_o,
    input wire logic [7:0] nand_io_o,
    input wire logic       nand_io_oe_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    // ****************************************************************
    // write cycle steps
    // ****************************************************************
    sequence set_cmd_s;
        $rose(nand_we_n_o) && nand_cle_o && nand_io_o == `NFS_CMD_SET;
    endsequence
    sequence addr_cyc_s;
        $rose(nand_we_n_o) && nand_ale_o;
    endsequence
    reset_idle_a: assert property (
        $fell(sys_rst_i) |-> nand_ce_n_o && nand_we_n_o && nand_re_n_o && !nand_io_oe_o)
        else $error("pins not idle after reset");
    strobe_ce_a: assert property (
        (!nand_we_n_o || !nand_re_n_o) |-> !nand_ce_n_o) else $error("strobe without select");
    cmd_code_a: assert property (
        $rose(nand_we_n_o) && nand_cle_o |-> nand_io_o inside {`NFS_CMD_SET, `NFS_CMD_GET,
        `NFS_CMD_STATUS, `NFS_CMD_READMODE}) else $error("unexpected command byte");
    set_addr_a: assert property (set_cmd_s |-> ##[1:8] addr_cyc_s)
        else $error("no address after set command");
    adl_gap_a: assert property (addr_cyc_s |-> nand_we_n_o [*4])
        else $error("data too soon after address");
    cle_ale_a: assert property (nand_cle_o |-> !nand_ale_o)
        else $error("command and address latch together");
    we_pulse_a: assert property ($fell(nand_we_n_o) |=> !nand_we_n_o ##1 nand_we_n_o)
        else $error("write strobe width wrong");
    we_stable_a: assert property (
        $rose(nand_we_n_o) |-> $stable(nand_io_o) && nand_io_oe_o && $stable(nand_cle_o))
        else $error("byte moved at write strobe");
    re_pulse_a: assert property (
        $fell(nand_re_n_o) |-> !nand_re_n_o [*8] ##1 nand_re_n_o)
        else $error("read strobe width wrong");
    read_release_a: assert property (!nand_re_n_o |-> !nand_io_oe_o)
        else $error("host drives bus during read");
endmodule : nfs_host_chk

bind nfs_host nfs_host_chk i_nfs_host_chk (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .nand_ce_n_o(nand_ce_n_o),
    .nand_cle_o(nand_cle_o), .nand_ale_o(nand_ale_o), .nand_we_n_o(nand_we_n_o),
    .nand_re_n_o(nand_re_n_o), .nand_io_o(nand_io_o), .nand_io_oe_o(nand_io_oe_o)
);

// ### verif/nfs_target.sv
// behavioural flash target answering set-features and get-features
`timescale 1ns/10ps
`include "nfs_map.svh"
module nfs_target #(
    parameter int FEAT_NS = 1000,
    parameter int ITC_NS  = 2000
) (
    input  wire logic       ce_n_i,
    input  wire logic       cle_i,
    input  wire logic       ale_i,
    input  wire logic       we_n_i,
    input  wire logic       re_n_i,
    input  wire logic [7:0] io_i,
    output logic      [7:0] io_o,
    output logic            rb_n_o
);
    logic [31:0] feat [0:255];
    logic [7:0]  cmd;
    logic [7:0]  fa;
    logic [7:0]  dout;
    logic [7:0]  last;
    logic [2:0]  cnt;
    logic        busy;
    logic        stat;
    int          nbytes;
    initial begin
        for (int i = 0; i < 256; i++)
            feat[i] = 32'h0000_0000;
        {busy, stat, cnt, cmd, fa, last, dout} = '0;
        nbytes = 0;
    end
    assign rb_n_o = !busy;
    // released bus shows the inverse of the last byte
    assign io_o = (!ce_n_i && !re_n_i) ? dout : ~last;
    always @(negedge re_n_i) begin
        dout = stat ? {1'b1, !busy, 6'h00} : feat[fa][8*cnt[1:0] +: 8];
        last = dout;
    end
    always @(posedge re_n_i) begin
        if (!stat)
            cnt = cnt + 3'd1;
    end
    always @(posedge we_n_i) begin
        if (!ce_n_i && cle_i) begin
            cmd = (io_i == `NFS_CMD_STATUS || io_i == `NFS_CMD_READMODE) ? cmd : io_i;
            stat = (io_i == `NFS_CMD_STATUS);
        end else if (!ce_n_i && ale_i && !busy) begin
            fa = io_i;
            cnt = 3'd0;
            if (cmd == `NFS_CMD_GET)
                fork begin #10 busy = 1'b1; #(FEAT_NS) busy = 1'b0; end join_none
        end else if (!ce_n_i && cmd == `NFS_CMD_SET) begin
            // every data strobe counts, so a surplus byte shows up
            nbytes++;
            if (cnt < 3'd4) begin
                feat[fa][8*cnt[1:0] +: 8] = io_i;
                cnt = cnt + 3'd1;
                if (cnt == 3'd4)
                    fork begin
                        #10 busy = 1'b1;
                        #((fa == `NFS_FA_TIMING && feat[fa][5:4] != 2'h0) ? ITC_NS : FEAT_NS);
                        busy = 1'b0;
                    end join_none
            end
        end
    end
endmodule : nfs_target

// ### verif/tb.sv
// self-checking bench for the feature host
`timescale 1ns/10ps
`include "nfs_map.svh"
module tb;
    logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        ce_n, cle, ale, we_n, re_n, io_oe, rb_n;
    logic [4:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd, exp_v [4], dat_v [4];
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rsp;
    logic [7:0]  hio, tio, io_bus, fa_v [4];
    int          bad_count, n_checks, n0;
    assign io_bus = io_oe ? hio : tio;
    nfs_host i_nfs_host (.sys_clk_i(clk), .sys_rst_i(rst), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .nand_ce_n_o(ce_n), .nand_cle_o(cle), .nand_ale_o(ale),
        .nand_we_n_o(we_n), .nand_re_n_o(re_n), .nand_io_o(hio), .nand_io_oe_o(io_oe),
        .nand_io_i(io_bus), .nand_rb_n_i(rb_n));
    nfs_target i_nfs_target (.ce_n_i(ce_n), .cle_i(cle), .ale_i(ale), .we_n_i(we_n),
        .re_n_i(re_n), .io_i(io_bus), .io_o(tio), .rb_n_o(rb_n));
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up
    task automatic axw(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        {awaddr, wdata} <= {a, d};
        {awvalid, wvalid, bready} <= 3'b111;
        do begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rsp = bresp;
        bready <= 1'b0;
    endtask : axw
    task automatic axr(input logic [4:0] a);
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        {rd, rsp} = {rdata, rresp};
        rready <= 1'b0;
    endtask : axr
    // program address and data, then fire
    task automatic go(input logic [7:0] fa, input logic [31:0] d, input logic [3:0] ctl);
        axw(5'h04, {24'h0, fa});
        axw(5'h08, d);
        axw(5'h00, {28'h0, ctl});
        chk("write resp", {30'h0, rsp}, {30'h0, `NFS_RESP_OKAY});
    endtask : go
    task automatic fin;
        rd = '0;
        for (int i = 0; i < 400 && rd[1] !== 1'b1; i++)
            axr(5'h10);
        chk("done", {31'h0, rd[1]}, 32'h1);
        axw(5'h00, 32'h0000_0008);
    endtask : fin
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        wrap_up();
    end
    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '1 >> 80;
        rst = 1'b1;
        wstrb = 4'hf;
        fa_v = '{8'h01, 8'h80, 8'h81, 8'h90};
        dat_v = '{32'hc3c3_c3fd, 32'h1234_56f3, 32'h0000_00fe, 32'h8888_8888};
        exp_v = '{32'h5, 32'h3, 32'h2, 32'h8};
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        axr(5'h14);
        chk("unmapped resp", {30'h0, rsp}, {30'h0, `NFS_RESP_SLVERR});
        axw(5'h14, 32'h0000_0000);
        chk("unmapped write", {30'h0, rsp}, {30'h0, `NFS_RESP_SLVERR});
        axr(5'h10);
        chk("idle status", {28'h0, rd[3:0]}, 32'h4);
        for (int i = 0; i < 3; i++) begin
            go(fa_v[i], 32'h0, 4'h2);
            fin();
            axr(5'h0c);
            chk("default", rd, 32'h0);
        end
        for (int i = 0; i < 4; i++) begin
            n0 = i_nfs_target.nbytes;
            go(fa_v[i], dat_v[i], i[0] ? 4'h5 : 4'h1);
            fin();
            chk("bytes taken", i_nfs_target.nbytes - n0, 32'h4);
            chk("stored", i_nfs_target.feat[fa_v[i]], exp_v[i]);
            go(fa_v[i], 32'h0, i[0] ? 4'h2 : 4'h6);
            fin();
            axr(5'h0c);
            chk("read back", rd, exp_v[i]);
        end
        axr(5'h10);
        chk("polled status", {24'h0, rd[15:8]}, 32'hc0);
        go(8'h80, 32'h0000_0001, 4'h1);
        axw(5'h00, 32'h0000_0001);
        axr(5'h10);
        chk("refused", {31'h0, rd[3]}, 32'h1);
        fin();
        axr(5'h10);
        chk("cleared", {28'h0, rd[3:0]}, 32'h4);
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        go(8'h80, 32'h0, 4'h2);
        fin();
        axr(5'h0c);
        chk("kept setting", rd, 32'h1);
        wrap_up();
    end
endmodule : tb
